// ---- pkg/dprmc_pkg.sv ----
package dprmc_pkg;
   // ===============================
   // timing
   localparam int CLK_PERIOD_NS       = 8;
   localparam int UNPLUG_DEBOUNCE_NS  = 2000;
   localparam int IRQ_PULSE_MAX_NS    = 1000;
   localparam int UNPLUG_DEBOUNCE_CYC = (UNPLUG_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IRQ_PULSE_MAX_CYC   = (IRQ_PULSE_MAX_NS / CLK_PERIOD_NS < 1) ? 1 : IRQ_PULSE_MAX_NS / CLK_PERIOD_NS;
   localparam int HPD_CNT_W           = 16;
   // ===============================
   // snooped dpcd locations and fields
   localparam logic [19:0] DPCD_LANE_COUNT_ADDR = 20'h00101;
   localparam logic [19:0] DPCD_LANE0_SET_ADDR  = 20'h00103;
   localparam logic [19:0] DPCD_SET_POWER_ADDR  = 20'h00600;
   localparam logic [7:0]  DPCD_RESET_VAL       = 8'h00;
   localparam int          LANE_CNT_LSB         = 0;
   localparam int          SWING_LSB            = 0;
   localparam int          PREEMPH_LSB          = 3;
   localparam int          PWR_LSB              = 0;
   localparam logic [1:0]  PWR_NORMAL           = 2'h1;
   localparam logic [1:0]  PWR_D3               = 2'h2;
   // ===============================
   // output levels
   localparam logic [1:0]  SWING_TMDS_600MV     = 2'h1;
   localparam logic [1:0]  LEVEL_RESET_VAL      = 2'h0;
   // ===============================
   // types
   typedef enum logic [2:0] {
      MODE_SHUTDOWN = 3'h0,
      MODE_STANDBY  = 3'h1,
      MODE_D3       = 3'h2,
      MODE_ACTIVE   = 3'h3,
      MODE_OUTDIS   = 3'h4
   } dprmc_mode_t;
   typedef struct packed {
      logic [HPD_CNT_W-1:0] lowCnt;
      logic                 unplugged;
   } dprmc_hpd_st_t;
   typedef struct packed {
      logic [7:0] laneCount;
      logic [7:0] lane0Set;
      logic       d3Entry;
      logic       d3Exit;
   } dprmc_dpcd_st_t;
   typedef struct packed {
      dprmc_mode_t mode;
      logic        hpdOut;
      logic        cadOut;
      logic        cadOe;
      logic        mlEn;
      logic        auxMonEn;
      logic        auxSrcEn;
      logic        auxSnkEn;
      logic        ddcEn;
      logic        i2cEn;
      logic        tmds;
      logic [1:0]  swing;
      logic [1:0]  preemph;
   } dprmc_ctl_st_t;
endpackage

// ---- verification/dprmc_aux_source.sv ----
`timescale 1ns/10ps
module dprmc_aux_source (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // request from bench
   input  wire logic        wrReq,
   input  wire logic [19:0] reqAddr,
   input  wire logic [7:0]  reqData,
   // snooped write toward the redriver
   output logic             auxWrValid,
   output logic [19:0]      auxWrAddr,
   output logic [7:0]       auxWrData
);
   // ===============================
   // one-cycle dpcd write, bus garbage between writes
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         auxWrValid <= 1'b0;
         auxWrAddr  <= 20'h00000;
         auxWrData  <= 8'h00;
      end else if (wrReq) begin
         // values chosen by bench, valid on retrain
         auxWrValid <= 1'b1;
         auxWrAddr  <= reqAddr;
         auxWrData  <= reqData;
      end else begin
         auxWrValid <= 1'b0;
         auxWrAddr  <= ~auxWrAddr;
         auxWrData  <= ~auxWrData;
      end
   end
endmodule

// ---- verification/dprmc_mode_ctrl_tb.sv ----
`timescale 1ns/10ps
module dprmc_mode_ctrl_tb;
   // ===============================
   // signals
   typedef struct packed {
      logic [9:0]  stim;
      logic [11:0] expv;
      logic [11:0] mask;
   } dprmc_tb_row_t;
   localparam int DEB = 8;
   localparam int IRQ = 4;
   logic        ref_clk, rst, enablePin, resetLowPinN, sinkHotplugIn, sinkCableDetectIn, streamActive;
   logic        wrReq, auxWrValid;
   logic [19:0] reqAddr, auxWrAddr;
   logic [7:0]  reqData, auxWrData;
   logic        i2cComplianceEn, i2cTestHotplug, i2cTestCableDetect, i2cAutoPdDisable, i2cLevelOverride;
   logic [1:0]  i2cSwing, i2cPreemph, outSwing, outPreemph;
   logic        i2cSinkAuxDisable, i2cDdcDisable;
   logic        sourceHotplugOut, sourceHotplugOe, sourceCableDetectOut, sourceCableDetectOe;
   logic        mainLinkOutEn, auxMonitorEn, auxSrcEn, auxSnkEn, ddcEn, i2cEn, tmdsMode;
   logic [2:0]  modeState;
   logic [11:0] obs;
   int          n_fail, num_checks;
   // stim: en reset_low_pin hpd cad strm ovr swing auxDis ddcDis
   // obs: mode hpo ml mon i2c tmds swing snk ddc
   dprmc_tb_row_t rows [8] = '{
      '{10'h1a0, 12'h120, 12'hfe0},
      '{10'h320, 12'h220, 12'hee0},
      '{10'h3a0, 12'h663, 12'hef3},
      '{10'h3a3, 12'h660, 12'hef3},
      '{10'h3e0, 12'h614, 12'he1c},
      '{10'h3fc, 12'h61c, 12'he1c},
      '{10'h380, 12'h800, 12'he80},
      '{10'h3a0, 12'h640, 12'hec0}
   };
   assign obs = {modeState, sourceHotplugOut, mainLinkOutEn, auxMonitorEn, i2cEn, tmdsMode, outSwing, auxSnkEn, ddcEn};
   // ===============================
   // instances
   dprmc_mode_ctrl #(.DEBOUNCE_CYC(DEB), .IRQ_CYC(IRQ)) dprmc_mode_ctrl_inst (
      .ref_clk, .rst, .enablePin, .resetLowPinN, .sinkHotplugIn, .sinkCableDetectIn, .streamActive,
      .auxWrValid, .auxWrAddr, .auxWrData, .i2cComplianceEn, .i2cTestHotplug, .i2cTestCableDetect,
      .i2cAutoPdDisable, .i2cLevelOverride, .i2cSwing, .i2cPreemph, .i2cSinkAuxDisable, .i2cDdcDisable,
      .sourceHotplugOut, .sourceHotplugOe, .sourceCableDetectOut, .sourceCableDetectOe,
      .mainLinkOutEn, .auxMonitorEn, .auxSrcEn, .auxSnkEn, .ddcEn, .i2cEn, .tmdsMode,
      .outSwing, .outPreemph, .modeState
   );
   dprmc_aux_source dprmc_aux_source_inst (
      .ref_clk, .rst, .wrReq, .reqAddr, .reqData, .auxWrValid, .auxWrAddr, .auxWrData
   );
   // ===============================
   // tasks
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
      num_checks++;
      if (seen !== expv) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask
   task automatic wait_mode(input logic [2:0] m);
      int i;
      i = 0;
      while (i < 40 && modeState !== m) begin
         settle(1);
         i++;
      end
      chk({13'h0, modeState}, {13'h0, m});
   endtask
   task automatic aux_wr(input logic [19:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wrReq   <= 1'b1;
      reqAddr <= a;
      reqData <= d;
      @(posedge ref_clk);
      wrReq <= 1'b0;
      settle(5);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ===============================
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // ===============================
   // sequence
   initial begin
      {rst, enablePin, resetLowPinN, sinkHotplugIn, sinkCableDetectIn, streamActive} = 6'h20;
      {wrReq, reqAddr, reqData} = 29'h0;
      {i2cComplianceEn, i2cTestHotplug, i2cTestCableDetect, i2cAutoPdDisable, i2cLevelOverride} = 5'h0;
      {i2cSwing, i2cPreemph, i2cSinkAuxDisable, i2cDdcDisable} = 6'h0;
      n_fail = 0;
      num_checks = 0;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      settle(1);
      chk({10'h0, modeState, mainLinkOutEn, auxSrcEn, sourceHotplugOe}, 16'h1);
      $display("reset done");
      for (int r = 0; r < 8; r++) begin
         @(posedge ref_clk);
         {enablePin, resetLowPinN, sinkHotplugIn, sinkCableDetectIn, streamActive, i2cLevelOverride,
          i2cSwing, i2cSinkAuxDisable, i2cDdcDisable} <= rows[r].stim;
         settle(3);
         chk({4'h0, obs & rows[r].mask}, {4'h0, rows[r].expv & rows[r].mask});
         $display("row %0d done", r);
      end
      aux_wr(dprmc_pkg::DPCD_LANE_COUNT_ADDR, 8'h02);
      chk({15'h0, mainLinkOutEn}, 16'h1);
      aux_wr(dprmc_pkg::DPCD_LANE0_SET_ADDR, 8'h0a);
      chk({12'h0, outSwing, outPreemph}, 16'h9);
      aux_wr(dprmc_pkg::DPCD_LANE_COUNT_ADDR, 8'h03);
      chk({12'h0, modeState, mainLinkOutEn}, 16'h8);
      aux_wr(dprmc_pkg::DPCD_LANE_COUNT_ADDR, 8'h02);
      chk({12'h0, modeState, mainLinkOutEn}, 16'h7);
      $display("dpcd done");
      @(posedge ref_clk);
      sinkHotplugIn <= 1'b0;
      repeat (IRQ - 1) @(posedge ref_clk);
      sinkHotplugIn <= 1'b1;
      settle(14);
      chk({13'h0, modeState}, 16'h3);
      @(posedge ref_clk);
      sinkHotplugIn <= 1'b0;
      settle(DEB - 2);
      chk({13'h0, modeState}, 16'h3);
      wait_mode(3'h1);
      chk({14'h0, auxMonitorEn, mainLinkOutEn}, 16'h0);
      @(posedge ref_clk);
      sinkHotplugIn <= 1'b1;
      wait_mode(3'h3);
      chk({15'h0, mainLinkOutEn}, 16'h1);
      $display("hot-plug done");
      aux_wr(dprmc_pkg::DPCD_SET_POWER_ADDR, 8'h02);
      wait_mode(3'h2);
      chk({13'h0, mainLinkOutEn, auxMonitorEn, i2cEn}, 16'h3);
      aux_wr(dprmc_pkg::DPCD_SET_POWER_ADDR, 8'h01);
      wait_mode(3'h3);
      aux_wr(dprmc_pkg::DPCD_SET_POWER_ADDR, 8'h02);
      wait_mode(3'h2);
      @(posedge ref_clk);
      sinkCableDetectIn <= 1'b1;
      wait_mode(3'h3);
      aux_wr(dprmc_pkg::DPCD_LANE_COUNT_ADDR, 8'h03);
      chk({13'h0, modeState}, 16'h3);
      $display("power-down done");
      @(posedge ref_clk);
      sinkCableDetectIn <= 1'b0;
      enablePin <= 1'b0;
      wait_mode(3'h0);
      chk({14'h0, sourceCableDetectOe, i2cEn}, 16'h1);
      @(posedge ref_clk);
      enablePin <= 1'b1;
      wait_mode(3'h3);
      chk({15'h0, mainLinkOutEn}, 16'h1);
      @(posedge ref_clk);
      resetLowPinN <= 1'b0;
      wait_mode(3'h0);
      chk({15'h0, i2cEn}, 16'h0);
      @(posedge ref_clk);
      resetLowPinN <= 1'b1;
      wait_mode(3'h3);
      chk({15'h0, mainLinkOutEn}, 16'h0);
      $display("pins done");
      @(posedge ref_clk);
      {i2cComplianceEn, i2cTestHotplug, i2cTestCableDetect} <= 3'h7;
      sinkHotplugIn <= 1'b0;
      sinkCableDetectIn <= 1'b0;
      settle(14);
      chk({10'h0, modeState, sourceHotplugOut, sourceCableDetectOut, tmdsMode}, 16'h1f);
      @(posedge ref_clk);
      i2cLevelOverride <= 1'b1;
      i2cSwing <= 2'h2;
      i2cPreemph <= 2'h2;
      settle(3);
      chk({12'h0, outSwing, outPreemph}, 16'ha);
      @(posedge ref_clk);
      i2cComplianceEn <= 1'b0;
      sinkCableDetectIn <= 1'b0;
      i2cAutoPdDisable <= 1'b1;
      settle(14);
      chk({13'h0, modeState}, 16'h3);
      $display("compliance done");
      tally_and_finish();
   end
endmodule

// ---- verilog/dprmc_dpcd_snoop.sv ----
`timescale 1ns/10ps
module dprmc_dpcd_snoop (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        clearDpcd,
   // snooped aux writes
   input  wire logic        snoopEn,
   input  wire logic        auxWrValid,
   input  wire logic [19:0] auxWrAddr,
   input  wire logic [7:0]  auxWrData,
   // local copy state
   output logic             dpcdValid,
   output logic             linkTrained,
   output logic [1:0]       trainSwing,
   output logic [1:0]       trainPreemph,
   output logic             d3Entry,
   output logic             d3Exit
);
   // ===============================
   // local dpcd copy
   dprmc_pkg::dprmc_dpcd_st_t st_ff;
   dprmc_pkg::dprmc_dpcd_st_t nxt_st;
   logic [4:0] laneCnt;
   logic [2:0] levelSum;
   logic [1:0] pwr;

   assign pwr = auxWrData[dprmc_pkg::PWR_LSB +: 2];

   always_comb begin
      nxt_st         = st_ff;
      nxt_st.d3Entry = 1'b0;
      nxt_st.d3Exit  = 1'b0;
      if (snoopEn && auxWrValid) begin
         unique case (auxWrAddr)
            dprmc_pkg::DPCD_LANE_COUNT_ADDR: nxt_st.laneCount = auxWrData;
            dprmc_pkg::DPCD_LANE0_SET_ADDR:  nxt_st.lane0Set = auxWrData;
            dprmc_pkg::DPCD_SET_POWER_ADDR: begin
               nxt_st.d3Entry = (pwr == dprmc_pkg::PWR_D3);
               nxt_st.d3Exit  = (pwr == dprmc_pkg::PWR_NORMAL);
            end
            default: nxt_st.d3Exit = 1'b0;
         endcase
      end
   end

   // rst or the reset pin (clearDpcd) clears the copy
   always_ff @(posedge ref_clk) begin
      if (rst || clearDpcd) begin
         st_ff <= '{laneCount: dprmc_pkg::DPCD_RESET_VAL, lane0Set: dprmc_pkg::DPCD_RESET_VAL,
                    d3Entry: 1'b0, d3Exit: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // forbidden lane count or level pair
   assign laneCnt      = st_ff.laneCount[dprmc_pkg::LANE_CNT_LSB +: 5];
   assign trainSwing   = st_ff.lane0Set[dprmc_pkg::SWING_LSB +: 2];
   assign trainPreemph = st_ff.lane0Set[dprmc_pkg::PREEMPH_LSB +: 2];
   assign levelSum     = {1'b0, trainSwing} + {1'b0, trainPreemph};
   assign dpcdValid    = ((laneCnt == 5'h00) || (laneCnt == 5'h01) || (laneCnt == 5'h02) || (laneCnt == 5'h04))
                         && (levelSum <= 3'h3);
   // outputs enabled once lanes are trained
   assign linkTrained  = (laneCnt != 5'h00);
   assign d3Entry      = st_ff.d3Entry;
   assign d3Exit       = st_ff.d3Exit;
endmodule

// ---- verilog/dprmc_hpd_filter.sv ----
`timescale 1ns/10ps
module dprmc_hpd_filter #(
   parameter int DEBOUNCE_CYC = dprmc_pkg::UNPLUG_DEBOUNCE_CYC,
   parameter int IRQ_CYC      = dprmc_pkg::IRQ_PULSE_MAX_CYC
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // hot-plug level
   input  wire logic hpdIn,
   output logic      unplugged
);
   // ===============================
   // low-time counter
   localparam int LIMIT = (DEBOUNCE_CYC > IRQ_CYC) ? DEBOUNCE_CYC : IRQ_CYC;
   localparam logic [dprmc_pkg::HPD_CNT_W-1:0] LIMIT_V = LIMIT[dprmc_pkg::HPD_CNT_W-1:0];
   dprmc_pkg::dprmc_hpd_st_t st_ff;
   dprmc_pkg::dprmc_hpd_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (hpdIn) begin
         nxt_st.lowCnt    = '0;
         nxt_st.unplugged = 1'b0;
      end else if (st_ff.lowCnt < LIMIT_V) begin
         nxt_st.lowCnt = st_ff.lowCnt + 1'b1;
      end else begin
         // only lows beyond the limit count
         nxt_st.unplugged = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign unplugged = st_ff.unplugged;
endmodule

// ---- verilog/dprmc_mode_ctrl.sv ----
`timescale 1ns/10ps
// Notes on behaviour
// - shutdown: hot-plug follows sink, i2c follows reset pin, rest off
// - reset pin low: i2c off, copy cleared
// - enable low keeps local dpcd copy
// - shutdown when enable or reset low
// - standby: i2c on, aux monitor off, outputs off
// - d3: outputs off, i2c on, aux monitored
// - snooped d3 entry command enters d3
// - cable detect high selects tmds mode
// - dp: levels from training or i2c
// - dp: source aux on, sink aux/ddc gated
// - dp: main link off until training enables
// - short hot-plug lows keep active mode
// - tmds swing defaults 600mVpp, i2c overrides
// - tmds mode ignores all aux traffic
// - compliance: i2c drives cable, and hot-plug when awake
// - compliance: i2c levels, auto power-down off
// - snooped dpcd writes copied locally
// - forbidden 101h/103h value disables outputs
// - valid copy returns to selected mode
// - standby to active on hot-plug high
// - d3 exit on command or cable high
// - inactive stream disables, active stream returns
module dprmc_mode_ctrl #(
   parameter int DEBOUNCE_CYC = dprmc_pkg::UNPLUG_DEBOUNCE_CYC,
   parameter int IRQ_CYC      = dprmc_pkg::IRQ_PULSE_MAX_CYC
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // device pins
   input  wire logic        enablePin,
   input  wire logic        resetLowPinN,
   input  wire logic        sinkHotplugIn,
   input  wire logic        sinkCableDetectIn,
   // main link monitor
   input  wire logic        streamActive,
   // snooped aux writes
   input  wire logic        auxWrValid,
   input  wire logic [19:0] auxWrAddr,
   input  wire logic [7:0]  auxWrData,
   // local i2c settings
   input  wire logic        i2cComplianceEn,
   input  wire logic        i2cTestHotplug,
   input  wire logic        i2cTestCableDetect,
   input  wire logic        i2cAutoPdDisable,
   input  wire logic        i2cLevelOverride,
   input  wire logic [1:0]  i2cSwing,
   input  wire logic [1:0]  i2cPreemph,
   input  wire logic        i2cSinkAuxDisable,
   input  wire logic        i2cDdcDisable,
   // source-side pins
   output logic             sourceHotplugOut,
   output logic             sourceHotplugOe,
   output logic             sourceCableDetectOut,
   output logic             sourceCableDetectOe,
   // path enables and levels
   output logic             mainLinkOutEn,
   output logic             auxMonitorEn,
   output logic             auxSrcEn,
   output logic             auxSnkEn,
   output logic             ddcEn,
   output logic             i2cEn,
   output logic             tmdsMode,
   output logic [1:0]       outSwing,
   output logic [1:0]       outPreemph,
   output logic [2:0]       modeState
);
   // ===============================
   // helpers
   dprmc_pkg::dprmc_ctl_st_t st_ff;
   dprmc_pkg::dprmc_ctl_st_t nxt_st;
   logic       effHpd;
   logic       effCad;
   logic       run;
   logic       unplugged;
   logic       autoDown;
   logic       snoopEn;
   logic       dpcdValid;
   logic       linkTrained;
   logic [1:0] trainSwing;
   logic [1:0] trainPreemph;
   logic       d3Entry;
   logic       d3Exit;
   logic       nxtAwake;
   logic       nxtDp;

   assign effHpd   = i2cComplianceEn ? i2cTestHotplug : sinkHotplugIn;
   assign effCad   = i2cComplianceEn ? i2cTestCableDetect : sinkCableDetectIn;
   assign run      = enablePin && resetLowPinN;
   // auto power-down can be switched off
   assign autoDown = unplugged && !i2cAutoPdDisable;
   assign snoopEn  = run && !st_ff.tmds && (st_ff.mode == dprmc_pkg::MODE_ACTIVE
                     || st_ff.mode == dprmc_pkg::MODE_D3 || st_ff.mode == dprmc_pkg::MODE_OUTDIS);

   // ===============================
   // submodules
   dprmc_hpd_filter #(
      .DEBOUNCE_CYC (DEBOUNCE_CYC),
      .IRQ_CYC      (IRQ_CYC)
   ) u_hpd (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .hpdIn     (effHpd),
      .unplugged (unplugged)
   );

   // reset pin low clears the copy
   dprmc_dpcd_snoop u_dpcd (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .clearDpcd    (!resetLowPinN),
      .snoopEn      (snoopEn),
      .auxWrValid   (auxWrValid),
      .auxWrAddr    (auxWrAddr),
      .auxWrData    (auxWrData),
      .dpcdValid    (dpcdValid),
      .linkTrained  (linkTrained),
      .trainSwing   (trainSwing),
      .trainPreemph (trainPreemph),
      .d3Entry      (d3Entry),
      .d3Exit       (d3Exit)
   );

   // ===============================
   // mode selection
   always_comb begin
      nxt_st   = st_ff;
      nxtAwake = 1'b0;
      nxtDp    = 1'b0;
      unique case (st_ff.mode)
         dprmc_pkg::MODE_SHUTDOWN: begin
            nxt_st.mode = dprmc_pkg::MODE_STANDBY;
         end
         dprmc_pkg::MODE_STANDBY: begin
            if (effHpd) begin
               nxt_st.mode = dprmc_pkg::MODE_ACTIVE;
            end
         end
         dprmc_pkg::MODE_ACTIVE: begin
            if (autoDown) begin
               nxt_st.mode = dprmc_pkg::MODE_STANDBY;
            end else if (!dpcdValid || !streamActive) begin
               nxt_st.mode = dprmc_pkg::MODE_OUTDIS;
            end else if (d3Entry && !st_ff.tmds) begin
               nxt_st.mode = dprmc_pkg::MODE_D3;
            end
         end
         dprmc_pkg::MODE_D3: begin
            if (autoDown) begin
               nxt_st.mode = dprmc_pkg::MODE_STANDBY;
            end else if (!dpcdValid) begin
               nxt_st.mode = dprmc_pkg::MODE_OUTDIS;
            end else if (d3Exit || effCad) begin
               nxt_st.mode = dprmc_pkg::MODE_ACTIVE;
            end
         end
         dprmc_pkg::MODE_OUTDIS: begin
            // return once copy and stream are good
            if (dpcdValid && streamActive) begin
               nxt_st.mode = autoDown ? dprmc_pkg::MODE_STANDBY : dprmc_pkg::MODE_ACTIVE;
            end
         end
         default: begin
            nxt_st.mode = dprmc_pkg::MODE_SHUTDOWN;
         end
      endcase
      // enable or reset pin low forces shutdown
      if (!run) begin
         nxt_st.mode = dprmc_pkg::MODE_SHUTDOWN;
      end
      // cable detect picks tmds while active
      if (nxt_st.mode == dprmc_pkg::MODE_ACTIVE) begin
         nxt_st.tmds = effCad;
      end
      nxtAwake = (nxt_st.mode != dprmc_pkg::MODE_SHUTDOWN);
      nxtDp    = !nxt_st.tmds;
      // hot-plug follows sink, compliance drives it when awake
      nxt_st.hpdOut   = (nxtAwake && i2cComplianceEn) ? i2cTestHotplug : sinkHotplugIn;
      nxt_st.cadOut   = i2cComplianceEn ? i2cTestCableDetect : sinkCableDetectIn;
      nxt_st.cadOe    = nxtAwake;
      nxt_st.i2cEn    = resetLowPinN;
      nxt_st.mlEn     = (nxt_st.mode == dprmc_pkg::MODE_ACTIVE) && (nxt_st.tmds || linkTrained);
      // monitor off in standby, on in d3 for dp
      nxt_st.auxMonEn = nxtDp && (nxt_st.mode == dprmc_pkg::MODE_ACTIVE
                        || nxt_st.mode == dprmc_pkg::MODE_D3 || nxt_st.mode == dprmc_pkg::MODE_OUTDIS);
      // aux and ddc paths in active dp
      nxt_st.auxSrcEn = nxtDp && (nxt_st.mode == dprmc_pkg::MODE_ACTIVE);
      nxt_st.auxSnkEn = nxt_st.auxSrcEn && !i2cSinkAuxDisable;
      nxt_st.ddcEn    = nxt_st.auxSrcEn && !i2cDdcDisable;
      if (i2cLevelOverride) begin
         nxt_st.swing   = i2cSwing;
         nxt_st.preemph = i2cPreemph;
      end else if (nxt_st.tmds) begin
         nxt_st.swing   = dprmc_pkg::SWING_TMDS_600MV;
         nxt_st.preemph = dprmc_pkg::LEVEL_RESET_VAL;
      end else begin
         nxt_st.swing   = trainSwing;
         nxt_st.preemph = trainPreemph;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_ff <= '{mode: dprmc_pkg::MODE_SHUTDOWN, swing: dprmc_pkg::LEVEL_RESET_VAL,
                    preemph: dprmc_pkg::LEVEL_RESET_VAL, default: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ===============================
   // outputs
   assign sourceHotplugOut     = st_ff.hpdOut;
   assign sourceHotplugOe      = 1'b1;
   assign sourceCableDetectOut = st_ff.cadOut;
   assign sourceCableDetectOe  = st_ff.cadOe;
   assign mainLinkOutEn        = st_ff.mlEn;
   assign auxMonitorEn         = st_ff.auxMonEn;
   assign auxSrcEn             = st_ff.auxSrcEn;
   assign auxSnkEn             = st_ff.auxSnkEn;
   assign ddcEn                = st_ff.ddcEn;
   assign i2cEn                = st_ff.i2cEn;
   assign tmdsMode             = st_ff.tmds;
   assign outSwing             = st_ff.swing;
   assign outPreemph           = st_ff.preemph;
   assign modeState            = st_ff.mode;

   // ===============================
   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   chk_shutdown_entry: assert property (!run |=> modeState == dprmc_pkg::MODE_SHUTDOWN)
      else $error("pin low did not force shutdown");
   chk_hpd_follow: assert property (!enablePin |=> sourceHotplugOut == $past(sinkHotplugIn))
      else $error("source hot-plug not following sink in shutdown");
   chk_shutdown_quiet: assert property (modeState == dprmc_pkg::MODE_SHUTDOWN |->
      !sourceCableDetectOe && !mainLinkOutEn && !auxSrcEn && !auxMonitorEn)
      else $error("output driven in shutdown");
   chk_i2c_off: assert property (!resetLowPinN |=> !i2cEn && !auxMonitorEn)
      else $error("i2c active with reset pin low");
   chk_standby_outs: assert property ($past(run) && modeState == dprmc_pkg::MODE_STANDBY |->
      !mainLinkOutEn && !auxMonitorEn && i2cEn)
      else $error("standby outputs wrong");
   chk_d3_outs: assert property (modeState == dprmc_pkg::MODE_D3 |-> !mainLinkOutEn && auxMonitorEn)
      else $error("d3 outputs wrong");
   chk_tmds_swing: assert property (tmdsMode && modeState == dprmc_pkg::MODE_ACTIVE
      && !$past(i2cLevelOverride) |-> outSwing == dprmc_pkg::SWING_TMDS_600MV)
      else $error("tmds default swing wrong");
   chk_tmds_no_aux: assert property (tmdsMode |-> !auxMonitorEn && !auxSrcEn)
      else $error("aux active in tmds mode");
   chk_invalid_dis: assert property (modeState == dprmc_pkg::MODE_ACTIVE && run && !autoDown
      && !dpcdValid |=> modeState == dprmc_pkg::MODE_OUTDIS && !mainLinkOutEn)
      else $error("forbidden dpcd value did not disable outputs");
   chk_train_gate: assert property (mainLinkOutEn && !tmdsMode |-> $past(linkTrained))
      else $error("main link enabled before training");

   cov_plug_in: cover property (modeState == dprmc_pkg::MODE_STANDBY ##1 modeState == dprmc_pkg::MODE_ACTIVE);
   cov_d3_enter: cover property (modeState == dprmc_pkg::MODE_ACTIVE ##1 modeState == dprmc_pkg::MODE_D3);
   cov_outdis_back: cover property (modeState == dprmc_pkg::MODE_OUTDIS ##1 modeState == dprmc_pkg::MODE_ACTIVE);
   cov_compliance: cover property (i2cComplianceEn && modeState == dprmc_pkg::MODE_ACTIVE);
endmodule
